// [core/pscr_consts.vh]
`ifndef PSCR_CONSTS_VH
`define PSCR_CONSTS_VH

// Register offsets on the serial register port
`define PSCR_ADDR_PKT_CTRL 6'h08
`define PSCR_ADDR_NODE_ADDR 6'h09
`define PSCR_ADDR_SLOT 6'h0a
`define PSCR_ADDR_IF_CTRL 6'h0b
`define PSCR_ADDR_OFFSET 6'h0c
`define PSCR_ADDR_CARRIER_HI 6'h0d
`define PSCR_ADDR_CARRIER_MID 6'h0e
`define PSCR_ADDR_CARRIER_LO 6'h0f

// Reset values
`define PSCR_RST_PKT_CTRL 8'h45
`define PSCR_RST_NODE_ADDR 8'h00
`define PSCR_RST_SLOT 8'h00
`define PSCR_RST_IF_CTRL 8'h0f
`define PSCR_RST_OFFSET 8'h00
`define PSCR_RST_CARRIER_HI 8'h1e
`define PSCR_RST_CARRIER_MID 8'hc4
`define PSCR_RST_CARRIER_LO 8'hec

// Writable bit masks, the rest hold zero
`define PSCR_MASK_PKT_CTRL 8'h77
`define PSCR_MASK_IF_CTRL 8'h3f
`define PSCR_MASK_CARRIER_HI 8'h3f
`define PSCR_MASK_FULL 8'hff

// Field positions
`define PSCR_WHITE_BIT 6
`define PSCR_FMT_HI 5
`define PSCR_FMT_LO 4
`define PSCR_CRC_BIT 2
`define PSCR_LEN_HI 1
`define PSCR_LEN_LO 0
`define PSCR_IF_HI 4

// Frame format select
`define PSCR_FMT_FIFO 2'h0
`define PSCR_FMT_SYNC 2'h1
`define PSCR_FMT_PN9 2'h2
`define PSCR_FMT_ASYNC 2'h3

// Frame length mode
`define PSCR_LEN_FIXED 2'h0
`define PSCR_LEN_VAR 2'h1
`define PSCR_LEN_INF 2'h2

// Address filter setting
`define PSCR_ADR_NONE 2'h0
`define PSCR_ADR_BC0 2'h2
`define PSCR_ADR_BC_BOTH 2'h3
`define PSCR_BCAST_LOW 8'h00
`define PSCR_BCAST_HIGH 8'hff

// Checksum and pseudo-random generator
`define PSCR_CRC_POLY 16'h8005
`define PSCR_CRC_INIT 16'hffff
`define PSCR_CRC_LAST 4'hf
`define PSCR_PN9_SEED 9'h1ff
`define PSCR_PN9_TAP 4

// Scaling of offset and intermediate frequency into carrier word units
`define PSCR_OFFSET_SHIFT 2
`define PSCR_IF_SHIFT 6

`endif

// [core/pscr_pn9.v]
`timescale 1ns/1ns
`default_nettype none
`include "pscr_consts.vh"

module pscr_pn9 (
	input wire core_clk,
	input wire rst_b,
	input wire load,
	input wire step,
	output wire pn_bit
);
	reg [8:0] lfsr;

	assign pn_bit = lfsr[0];

	// x^9 + x^5 + 1, shared by whitening and the random test stream
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lfsr <= `PSCR_PN9_SEED;
		end else if (load) begin
			lfsr <= `PSCR_PN9_SEED;
		end else if (step) begin
			lfsr <= {lfsr[0] ^ lfsr[`PSCR_PN9_TAP + 1], lfsr[8:1]};
		end
	end
endmodule

`default_nettype wire

// [core/pscr_regs.v]
`timescale 1ns/1ns
`default_nettype none
`include "pscr_consts.vh"

module pscr_regs (
	input wire core_clk,
	input wire rst_b,
	input wire [5:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire [7:0] frame_length_value,
	input wire [1:0] address_filter_setting,
	input wire [15:0] rf_slot_index_spacing_word,
	input wire tx_mode,
	input wire pkt_start,
	input wire bit_en,
	input wire tx_fifo_bit,
	input wire rx_bit,
	input wire serial_input_pin,
	output reg tx_line_bit,
	output reg general_output_pins,
	output reg [7:0] rx_byte,
	output reg rx_byte_valid,
	output reg pkt_done,
	output reg crc_ok,
	output reg addr_reject,
	output reg len_reject,
	output wire pkt_busy,
	output reg [26:0] synth_tx_word,
	output reg [26:0] synth_rx_word
);
	localparam ST_IDLE = 2'h0;
	localparam ST_BODY = 2'h1;
	localparam ST_CRC = 2'h2;

	reg [7:0] packet_automation_control;
	reg [7:0] node_filter_address_reg;
	reg [7:0] rf_slot_index_reg;
	reg [7:0] intermediate_carrier_base_word_control;
	reg [7:0] synth_offset_control;
	reg [7:0] carrier_word_high;
	reg [7:0] carrier_word_mid;
	reg [7:0] carrier_word_low;

	reg [1:0] state;
	reg [2:0] bit_cnt;
	reg [8:0] byte_cnt;
	reg [6:0] shift;
	reg [7:0] pkt_len;
	reg [15:0] crc;
	reg [3:0] crc_cnt;

	wire whitening_enable;
	wire [1:0] frame_format_select;
	wire checksum_enable;
	wire [1:0] frame_length_mode;
	wire [4:0] intermediate_carrier_base_word_word;
	wire [23:0] carrier_base_word;
	wire pn_bit;
	wire packet_path;
	wire serial_mode;
	wire active;
	wire wmask;
	wire data_bit;
	wire [7:0] byte_val;
	wire [8:0] next_byte_cnt;
	wire [8:0] total_bytes;
	wire [8:0] addr_index;
	wire addr_ok;
	wire [15:0] next_crc;
	wire [23:0] slot_product;
	wire [26:0] tuned_word;

	function [15:0] crc_step;
		input [15:0] c;
		input b;
		begin
			crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `PSCR_CRC_POLY : 16'h0000);
		end
	endfunction

	function [7:0] masked;
		input [7:0] d;
		input [7:0] m;
		begin
			masked = d & m;
		end
	endfunction

	assign whitening_enable = packet_automation_control[`PSCR_WHITE_BIT];
	assign frame_format_select = packet_automation_control[`PSCR_FMT_HI:`PSCR_FMT_LO];
	assign checksum_enable = packet_automation_control[`PSCR_CRC_BIT];
	assign frame_length_mode = packet_automation_control[`PSCR_LEN_HI:`PSCR_LEN_LO];
	assign intermediate_carrier_base_word_word = intermediate_carrier_base_word_control[`PSCR_IF_HI:0];
	assign carrier_base_word = {carrier_word_high, carrier_word_mid, carrier_word_low};

	// Random format only changes the transmit source, receive stays on the FIFO path
	assign packet_path = (frame_format_select == `PSCR_FMT_FIFO) || (frame_format_select == `PSCR_FMT_PN9);
	assign serial_mode = (frame_format_select == `PSCR_FMT_SYNC) || (frame_format_select == `PSCR_FMT_ASYNC);
	assign active = (state != ST_IDLE);
	assign pkt_busy = active;
	assign wmask = whitening_enable & pn_bit;
	assign data_bit = tx_mode ? tx_fifo_bit : (rx_bit ^ wmask);
	assign byte_val = {shift, data_bit};
	assign next_byte_cnt = byte_cnt + 9'h001;
	// Variable length counts the length byte itself plus the payload
	assign total_bytes = (frame_length_mode == `PSCR_LEN_VAR) ? ({1'b0, pkt_len} + 9'h001) :
		{1'b0, frame_length_value};
	assign addr_index = (frame_length_mode == `PSCR_LEN_VAR) ? 9'h001 : 9'h000;
	assign addr_ok = (byte_val == node_filter_address_reg) ||
		((address_filter_setting == `PSCR_ADR_BC0 || address_filter_setting == `PSCR_ADR_BC_BOTH) &&
		byte_val == `PSCR_BCAST_LOW) ||
		(address_filter_setting == `PSCR_ADR_BC_BOTH && byte_val == `PSCR_BCAST_HIGH);
	assign next_crc = crc_step(crc, data_bit);
	// Both operands widened first so the product keeps all 24 bits
	assign slot_product = {16'h0000, rf_slot_index_reg} * {8'h00, rf_slot_index_spacing_word};
	assign tuned_word = {3'h0, carrier_base_word} + {3'h0, slot_product} +
		({{19{synth_offset_control[7]}}, synth_offset_control} << `PSCR_OFFSET_SHIFT);

	pscr_pn9 u_pn9 (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.load(pkt_start),
		.step(bit_en & (active | (tx_mode & frame_format_select == `PSCR_FMT_PN9))),
		.pn_bit(pn_bit)
	);

	// Register writes; only writable bits are stored
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			packet_automation_control <= `PSCR_RST_PKT_CTRL;
			node_filter_address_reg <= `PSCR_RST_NODE_ADDR;
			rf_slot_index_reg <= `PSCR_RST_SLOT;
			intermediate_carrier_base_word_control <= `PSCR_RST_IF_CTRL;
			synth_offset_control <= `PSCR_RST_OFFSET;
			carrier_word_high <= `PSCR_RST_CARRIER_HI;
			carrier_word_mid <= `PSCR_RST_CARRIER_MID;
			carrier_word_low <= `PSCR_RST_CARRIER_LO;
		end else if (reg_wr) begin
			case (reg_addr)
				`PSCR_ADDR_PKT_CTRL: packet_automation_control <= masked(reg_wdata, `PSCR_MASK_PKT_CTRL);
				`PSCR_ADDR_NODE_ADDR: node_filter_address_reg <= reg_wdata;
				`PSCR_ADDR_SLOT: rf_slot_index_reg <= reg_wdata;
				`PSCR_ADDR_IF_CTRL: intermediate_carrier_base_word_control <= masked(reg_wdata, `PSCR_MASK_IF_CTRL);
				`PSCR_ADDR_OFFSET: synth_offset_control <= reg_wdata;
				`PSCR_ADDR_CARRIER_HI: carrier_word_high <= masked(reg_wdata, `PSCR_MASK_CARRIER_HI);
				`PSCR_ADDR_CARRIER_MID: carrier_word_mid <= reg_wdata;
				`PSCR_ADDR_CARRIER_LO: carrier_word_low <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// Registered read data; unmapped offsets read zero
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`PSCR_ADDR_PKT_CTRL: reg_rdata <= packet_automation_control;
				`PSCR_ADDR_NODE_ADDR: reg_rdata <= node_filter_address_reg;
				`PSCR_ADDR_SLOT: reg_rdata <= rf_slot_index_reg;
				`PSCR_ADDR_IF_CTRL: reg_rdata <= intermediate_carrier_base_word_control;
				`PSCR_ADDR_OFFSET: reg_rdata <= synth_offset_control;
				`PSCR_ADDR_CARRIER_HI: reg_rdata <= carrier_word_high;
				`PSCR_ADDR_CARRIER_MID: reg_rdata <= carrier_word_mid;
				`PSCR_ADDR_CARRIER_LO: reg_rdata <= carrier_word_low;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Synthesizer words in carrier units: base + slot*spacing + offset, minus IF in receive
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			synth_tx_word <= 27'h0000000;
			synth_rx_word <= 27'h0000000;
		end else begin
			synth_tx_word <= tuned_word;
			synth_rx_word <= tuned_word - ({22'h000000, intermediate_carrier_base_word_word} << `PSCR_IF_SHIFT);
		end
	end

	// Serial modes bypass the packet engine; async passes every clock, sync per bit
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_line_bit <= 1'b0;
			general_output_pins <= 1'b0;
		end else begin
			if (frame_format_select == `PSCR_FMT_ASYNC) begin
				tx_line_bit <= serial_input_pin;
				general_output_pins <= rx_bit;
			end else if (bit_en) begin
				if (serial_mode) begin
					tx_line_bit <= serial_input_pin;
					general_output_pins <= rx_bit;
				end else begin
					general_output_pins <= 1'b0;
					if (!tx_mode) begin
						tx_line_bit <= 1'b0;
					end else if (frame_format_select == `PSCR_FMT_PN9) begin
						tx_line_bit <= pn_bit;
					end else if (state == ST_CRC) begin
						tx_line_bit <= crc[15] ^ wmask;
					end else if (state == ST_BODY) begin
						tx_line_bit <= tx_fifo_bit ^ wmask;
					end else begin
						tx_line_bit <= 1'b0;
					end
				end
			end
		end
	end

	// Packet engine: byte framing, length, address filter and checksum
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			bit_cnt <= 3'h0;
			byte_cnt <= 9'h000;
			shift <= 7'h00;
			pkt_len <= 8'h00;
			crc <= `PSCR_CRC_INIT;
			crc_cnt <= 4'h0;
			rx_byte <= 8'h00;
			rx_byte_valid <= 1'b0;
			pkt_done <= 1'b0;
			crc_ok <= 1'b0;
			addr_reject <= 1'b0;
			len_reject <= 1'b0;
		end else begin
			rx_byte_valid <= 1'b0;
			pkt_done <= 1'b0;
			addr_reject <= 1'b0;
			len_reject <= 1'b0;
			if (pkt_start && packet_path && !(tx_mode && frame_format_select == `PSCR_FMT_PN9)) begin
				state <= ST_BODY;
				bit_cnt <= 3'h0;
				byte_cnt <= 9'h000;
				crc <= `PSCR_CRC_INIT;
				crc_cnt <= 4'h0;
				crc_ok <= 1'b0;
			end else if (bit_en && packet_path) begin
				case (state)
					ST_BODY: begin
						shift <= byte_val[6:0];
						bit_cnt <= bit_cnt + 3'h1;
						if (checksum_enable) begin
							crc <= next_crc;
						end
						if (bit_cnt == 3'h7) begin
							byte_cnt <= next_byte_cnt;
							if (!tx_mode) begin
								rx_byte <= byte_val;
								rx_byte_valid <= 1'b1;
							end
							if (byte_cnt == 9'h000 && frame_length_mode == `PSCR_LEN_VAR) begin
								pkt_len <= byte_val;
								if (!tx_mode && byte_val > frame_length_value) begin
									len_reject <= 1'b1;
									state <= ST_IDLE;
								end
							end else if (!tx_mode && byte_cnt == addr_index &&
								address_filter_setting != `PSCR_ADR_NONE && !addr_ok) begin
								addr_reject <= 1'b1;
								state <= ST_IDLE;
							end else if (frame_length_mode != `PSCR_LEN_INF &&
								next_byte_cnt == total_bytes) begin
								if (checksum_enable) begin
									state <= ST_CRC;
								end else begin
									state <= ST_IDLE;
									pkt_done <= 1'b1;
								end
							end
						end
					end
					ST_CRC: begin
						crc_cnt <= crc_cnt + 4'h1;
						// Transmit shifts the remainder out; receive folds it back in
						if (tx_mode) begin
							crc <= {crc[14:0], 1'b0};
						end else begin
							crc <= next_crc;
						end
						if (crc_cnt == `PSCR_CRC_LAST) begin
							state <= ST_IDLE;
							pkt_done <= 1'b1;
							crc_ok <= tx_mode | (next_crc == 16'h0000);
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end
endmodule

`default_nettype wire

// [tb/pscr_regs_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module pscr_regs_chk (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [5:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] address_filter_setting,
	input wire logic [15:0] rf_slot_index_spacing_word,
	input wire logic addr_reject,
	input wire logic rx_byte_valid,
	input wire logic pkt_done,
	input wire logic [26:0] synth_tx_word,
	input wire logic [26:0] synth_rx_word
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	a_unmapped_zero: assert property (reg_rd && (reg_addr < 6'h08 || reg_addr > 6'h0f) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_ctrl_spare_bits: assert property (reg_rd && reg_addr == 6'h08 |=> !reg_rdata[7] && !reg_rdata[3])
		else $error("control spare bits set");
	a_if_spare_bits: assert property (reg_rd && reg_addr == 6'h0b |=> reg_rdata[7:6] == 2'b00)
		else $error("if control spare bits set");
	a_carrier_top_zero: assert property (reg_rd && reg_addr == 6'h0d |=> reg_rdata[7:6] == 2'b00)
		else $error("carrier top bits set");
	a_node_addr_back: assert property (reg_wr && reg_addr == 6'h09 ##1 !reg_wr
		##1 reg_rd && reg_addr == 6'h09 |=> reg_rdata == $past(reg_wdata, 3))
		else $error("node address read back wrong");
	// Synth words only move after a write or a spacing change
	a_synth_steady: assert property ((rst_b && !reg_wr && $stable(rf_slot_index_spacing_word)) [*2] |=>
		$stable(synth_tx_word) && $stable(synth_rx_word))
		else $error("synth word moved without cause");
	a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without read");
	a_no_filter_pass: assert property (address_filter_setting == 2'h0 && $past(address_filter_setting) == 2'h0
		|-> !addr_reject)
		else $error("address reject with filtering off");
	a_done_pulse: assert property (pkt_done |=> !pkt_done)
		else $error("packet done longer than one cycle");
	c_rx_byte: cover property (rx_byte_valid);
	c_reject: cover property (addr_reject);
	c_done: cover property (pkt_done);
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic core_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, tx_mode = 0, pkt_start = 0, bit_en = 0;
	logic tx_fifo_bit = 0, rx_bit = 0, serial_input_pin = 0;
	logic [5:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, frame_length_value = 8'h01;
	logic [1:0] address_filter_setting = 0;
	logic [15:0] rf_slot_index_spacing_word = 16'h1234;
	logic [7:0] reg_rdata, rx_byte;
	logic tx_line_bit, general_output_pins, rx_byte_valid, pkt_done, crc_ok, addr_reject, len_reject, pkt_busy;
	logic [26:0] synth_tx_word, synth_rx_word, etx;
	int num_errors = 0, n_checks = 0;
	pscr_regs dut_u (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .frame_length_value(frame_length_value),
		.address_filter_setting(address_filter_setting), .rf_slot_index_spacing_word(rf_slot_index_spacing_word),
		.tx_mode(tx_mode), .pkt_start(pkt_start), .bit_en(bit_en), .tx_fifo_bit(tx_fifo_bit), .rx_bit(rx_bit),
		.serial_input_pin(serial_input_pin), .tx_line_bit(tx_line_bit), .general_output_pins(general_output_pins),
		.rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid), .pkt_done(pkt_done), .crc_ok(crc_ok),
		.addr_reject(addr_reject), .len_reject(len_reject), .pkt_busy(pkt_busy),
		.synth_tx_word(synth_tx_word), .synth_rx_word(synth_rx_word));
	initial forever #4 core_clk = ~core_clk;
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [26:0] got, input logic [26:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic start();
		@(posedge core_clk);
		pkt_start <= 1'b1;
		@(posedge core_clk);
		pkt_start <= 1'b0;
	endtask
	// Line bits go out most significant first, one per clock
	task automatic sendb(input logic [7:0] d);
		@(posedge core_clk);
		bit_en <= 1'b1;
		rx_bit <= d[7];
		for (int i = 6; i >= 0; i--) begin
			@(posedge core_clk);
			rx_bit <= d[i];
		end
		@(posedge core_clk);
		bit_en <= 1'b0;
	endtask
	task automatic t_regs();
		logic [7:0] rv [8] = '{8'h45, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h1e, 8'hc4, 8'hec};
		logic [7:0] wv [8] = '{8'hf6, 8'hff, 8'hff, 8'hdf, 8'hff, 8'hff, 8'hff, 8'hff};
		logic [7:0] ev [8] = '{8'h76, 8'hff, 8'hff, 8'h1f, 8'hff, 8'h3f, 8'hff, 8'hff};
		for (int i = 0; i < 8; i++)
			rd(6'h08 + 6'(i), rv[i]);
		rd(6'h07, 8'h00);
		wr(6'h10, 8'hff);
		rd(6'h10, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(6'h08 + 6'(i), wv[i]);
			rd(6'h08 + 6'(i), ev[i]);
		end
	endtask
	task automatic t_synth();
		wr(6'h0a, 8'hff);
		wr(6'h0c, 8'h80);
		wr(6'h0d, 8'h10);
		wr(6'h0e, 8'h00);
		wr(6'h0f, 8'h00);
		wr(6'h0b, 8'h1f);
		repeat (2) @(posedge core_clk);
		etx = 27'h100000 + 27'd255 * 27'h1234 - 27'd512;
		#1 chk(synth_tx_word, etx);
		chk(synth_rx_word, etx - 27'd1984);
	endtask
	task automatic rx_one(input logic [7:0] cfg, input logic [7:0] d, input logic [7:0] e);
		wr(6'h08, cfg);
		start();
		sendb(d);
		#1 chk(rx_byte_valid, 1'b1);
		chk(rx_byte, e);
		chk(pkt_done, 1'b1);
		chk(pkt_busy, 1'b0);
		chk(general_output_pins, 1'b0);
	endtask
	function automatic logic [15:0] crc16(input logic [7:0] d);
		logic [15:0] c;
		c = 16'hffff;
		for (int i = 7; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
		return c;
	endfunction
	task automatic t_crc(input logic [15:0] flip, input logic e);
		logic [15:0] c;
		c = crc16(8'h3c) ^ flip;
		wr(6'h08, 8'h04);
		start();
		sendb(8'h3c);
		#1 chk(pkt_busy, 1'b1);
		sendb(c[15:8]);
		sendb(c[7:0]);
		#1 chk(pkt_done, 1'b1);
		chk(crc_ok, e);
	endtask
	// One transmit bit per pulse; the line bit is registered at that edge
	task automatic txb(input logic b, input logic e);
		@(posedge core_clk);
		bit_en <= 1'b1;
		tx_fifo_bit <= b;
		@(posedge core_clk);
		bit_en <= 1'b0;
		#1 chk(tx_line_bit, e);
	endtask
	task automatic t_tx_crc();
		logic [23:0] s;
		s = {8'h3c, crc16(8'h3c)};
		wr(6'h08, 8'h04);
		tx_mode <= 1'b1;
		start();
		for (int i = 23; i >= 0; i--)
			txb(s[i], s[i]);
		chk(pkt_done, 1'b1);
		chk(crc_ok, 1'b1);
		@(posedge core_clk);
		tx_mode <= 1'b0;
	endtask
	task automatic t_pn9();
		logic [31:0] s;
		s = 32'h0;
		s[8:0] = 9'h1ff;
		for (int n = 0; n < 16; n++)
			s[n + 9] = s[n] ^ s[n + 5];
		wr(6'h08, 8'h20);
		tx_mode <= 1'b1;
		start();
		for (int n = 0; n < 16; n++)
			txb(1'b0, s[n]);
		chk(pkt_busy, 1'b0);
		@(posedge core_clk);
		tx_mode <= 1'b0;
	endtask
	task automatic ser(input logic [7:0] cfg);
		wr(6'h08, cfg);
		for (int v = 0; v < 2; v++) begin
			@(posedge core_clk);
			serial_input_pin <= v[0];
			rx_bit <= !v[0];
			bit_en <= 1'b1;
			@(posedge core_clk);
			bit_en <= 1'b0;
			#1 chk(tx_line_bit, v[0]);
			chk(general_output_pins, !v[0]);
		end
	endtask
	// Reject pulses may trail the last bit, so a short window is scanned
	task automatic pkt(input logic [1:0] f, input logic [7:0] l, input logic [7:0] d, input logic [2:0] e);
		logic [2:0] hit;
		@(posedge core_clk);
		address_filter_setting <= f;
		frame_length_value <= l;
		start();
		sendb(d);
		#1 hit = {addr_reject, len_reject, rx_byte_valid};
		repeat (3) begin
			@(posedge core_clk);
			#1 hit = hit | {addr_reject, len_reject, 1'b0};
		end
		chk(hit[2:1], e[2:1]);
		if (e[0])
			chk(hit[0], 1'b1);
	endtask
	task automatic t_filter();
		logic [1:0] fs [6] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h3, 2'h2};
		logic [7:0] by [6] = '{8'h44, 8'h33, 8'h00, 8'h00, 8'hff, 8'hff};
		logic [2:0] ex [6] = '{3'h4, 3'h1, 3'h1, 3'h4, 3'h1, 3'h4};
		wr(6'h09, 8'h33);
		wr(6'h08, 8'h00);
		for (int i = 0; i < 6; i++)
			pkt(fs[i], 8'h01, by[i], ex[i]);
		wr(6'h08, 8'h01);
		pkt(2'h0, 8'h02, 8'h03, 3'h2);
		pkt(2'h0, 8'h02, 8'h01, 3'h0);
		sendb(8'h77);
		#1 chk(pkt_done, 1'b1);
		wr(6'h08, 8'h02);
		pkt(2'h0, 8'h01, 8'h55, 3'h0);
		chk(pkt_busy, 1'b1);
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		t_regs();
		t_synth();
		rx_one(8'h00, 8'ha5, 8'ha5);
		rx_one(8'h40, 8'ha5, 8'h5a);
		rx_one(8'h20, 8'h3c, 8'h3c);
		t_crc(16'h0000, 1'b1);
		t_crc(16'h0001, 1'b0);
		t_tx_crc();
		t_pn9();
		ser(8'h30);
		ser(8'h10);
		t_filter();
		conclude();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		conclude();
	end
endmodule
bind pscr_regs pscr_regs_chk chk_u (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .address_filter_setting(address_filter_setting),
	.rf_slot_index_spacing_word(rf_slot_index_spacing_word), .addr_reject(addr_reject), .rx_byte_valid(rx_byte_valid),
	.pkt_done(pkt_done), .synth_tx_word(synth_tx_word), .synth_rx_word(synth_rx_word));
`default_nettype wire
